// ===== hdl/udis_sources.sv
// interrupt source register with command-driven 4-byte readout
module udis_sources
#(
    parameter int FRAME_CYCLES = udis_pkg::PSEUDO_FRAME_CYCLES
)
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // parallel command interface
    input wire logic writeStrobe,
    input wire logic commandPhase,
    input wire logic [7:0] writeData,
    input wire logic readStrobe,
    output logic [7:0] readData,
    // endpoint events, one-cycle pulses
    input wire logic [udis_pkg::ENDPOINT_COUNT-1:0] endpointEvent,
    input wire logic controlInEvent,
    input wire logic controlOutEvent,
    // bus and transfer events, one-cycle pulses
    input wire logic shortPacketDone,
    input wire logic dmaCountDone,
    input wire logic frameStartSeen,
    input wire logic resumeSeen,
    input wire logic busResetSeen,
    // bus line idle level, sampled at reset
    input wire logic busIdle,
    // enable mask and interrupt request
    input wire logic [udis_pkg::SOURCE_W-1:0] interruptEnable,
    output logic interruptRequest,
    output logic busSleepState
);
    import udis_pkg::*;

    // all state of this module outside the timer lives in one struct:
    // sticky flags, the live sleep bit, the readout sequence and the request.
    // the snapshot costs a second word of flops, but without it an event that lands
    // between byte reads could tear the word the host sees
    typedef struct packed {
        logic [SOURCE_W-1:0] flags; // sticky sources, live bit kept apart
        logic sleep; // bus sleep state
        udis_read_state_t rdState; // readout sequence state
        logic [1:0] byteIdx; // byte of the snapshot now presented
        logic [SOURCE_W-1:0] snap; // word frozen at the command
        logic [7:0] dataOut; // byte presented to the host
        logic irq; // registered interrupt request
    } udis_src_state_t;

    udis_src_state_t state_r;
    udis_src_state_t state_nxt;
    logic [SOURCE_W-1:0] setVec; // sources raised this cycle
    logic [SOURCE_W-1:0] clearVec; // sources consumed by a finished read
    logic [SOURCE_W-1:0] liveWord; // word as the host would see it now
    logic [ENDPOINT_COUNT-1:0] endpointSet; // endpoint events in flag order
    logic busActivity; // any bus event that proves the bus is awake

    // timer link; the timer only reports, the sleep bit itself is kept here
    udis_frame_if frm();

    // pick one byte of a word, low byte first
    function automatic logic [7:0] byteOf(input logic [SOURCE_W-1:0] w, input logic [1:0] idx);
        byteOf = w[8*idx +: 8];
    endfunction : byteOf

    // bus traffic of any kind: restarts the timer and wakes the bus
    function automatic logic busActive(input logic frameStart, input logic resume,
        input logic busReset);
        busActive = frameStart | resume | busReset;
    endfunction : busActive

    // pseudo frame timer; it keeps ticking in suspend so the pseudo flag
    // goes on marking frames while the host is away
    udis_frame_timer #(
        .FRAME_CYCLES(FRAME_CYCLES)
    ) u_timer (
        .clock(clock),
        .srst(srst),
        .frm(frm)
    );

    assign frm.frameStart = frameStartSeen;
    assign frm.wakeEvent = resumeSeen | busResetSeen;
    // one decode shared by the sleep bit and the suspend change flag
    assign busActivity = busActive(frameStartSeen, resumeSeen, busResetSeen);

    // endpoint flags laid out in ascending endpoint order
    genvar g;
    generate
        for (g = 0; g < ENDPOINT_COUNT; g++)
        begin : g_ep
            assign endpointSet[g] = endpointEvent[g];
        end
    endgenerate

    // event sources placed at their flag positions
    // every bit of setVec is written here so that a single process drives it
    // the reserved top byte never gets a set, so it can only ever read zero
    always_comb
    begin
        setVec[SOURCE_W-1:BIT_ENDPOINT_BASE + ENDPOINT_COUNT] = '0;
        setVec[BIT_ENDPOINT_BASE +: ENDPOINT_COUNT] = endpointSet;
        setVec[BIT_CTRL_IN] = controlInEvent;
        setVec[BIT_CTRL_OUT] = controlOutEvent;
        setVec[BIT_BUS_SLEEP] = 1'b0; // live bit, never sticky
        setVec[BIT_SHORT_PACKET] = shortPacketDone;
        setVec[BIT_PSEUDO_FRAME] = frm.pseudoTick;
        setVec[BIT_FRAME_START] = frameStartSeen;
        setVec[BIT_DMA_DONE] = dmaCountDone;
        // only a real awake to suspend change is flagged, not a report the bus cancels
        setVec[BIT_SUSPEND_CHANGE] = frm.missedSuspend & ~state_r.sleep & ~busActivity;
        setVec[BIT_RESUME] = resumeSeen;
        setVec[BIT_BUS_RESET] = busResetSeen;
    end

    // live view: sticky flags plus the current sleep bit, reserved forced low
    always_comb
    begin
        liveWord = state_r.flags & ~RESERVED_MASK & ~LIVE_MASK;
        liveWord[BIT_BUS_SLEEP] = state_r.sleep;
    end

    // next state of the whole block
    // the readout runs: command, then one byte per read strobe, low byte first.
    // readData is registered, so a byte appears the cycle after its strobe
    // and stands until the next strobe or command.
    // a command always wins over a read strobe in the same cycle
    always_comb
    begin
        state_nxt = state_r;
        clearVec = '0;
        // sleep state: entered by missed frames, left on any bus activity
        // activity wins over a missed-frame report in the same cycle,
        // since traffic proves that the bus is awake
        if (busActivity)
            state_nxt.sleep = 1'b0;
        else if (frm.missedSuspend)
            state_nxt.sleep = 1'b1;
        // command and data phases
        if (writeStrobe && commandPhase)
        begin
            if (writeData == CMD_READ_SOURCES)
            begin
                // freeze the word so all four bytes are coherent
                state_nxt.rdState = READ_ACTIVE;
                state_nxt.snap = liveWord;
                state_nxt.byteIdx = 2'h0;
                state_nxt.dataOut = byteOf(liveWord, 2'h0);
            end
            else
            begin
                // other commands belong to other blocks
                state_nxt.rdState = READ_IDLE;
                state_nxt.dataOut = 8'h00;
            end
        end
        else if (readStrobe)
        begin
            case (state_r.rdState)
                READ_ACTIVE:
                begin
                    if (state_r.byteIdx == LAST_BYTE)
                    begin
                        // only a full four byte read consumes the flags
                        state_nxt.rdState = READ_IDLE;
                        clearVec = state_r.snap & ~LIVE_MASK;
                        state_nxt.dataOut = 8'h00;
                    end
                    else
                    begin
                        state_nxt.byteIdx = state_r.byteIdx + 2'h1;
                        state_nxt.dataOut = byteOf(state_r.snap, state_r.byteIdx + 2'h1);
                    end
                end
                READ_IDLE:
                begin
                    // reads outside a sequence return zero
                    state_nxt.dataOut = 8'h00;
                end
                default:
                begin
                    state_nxt.rdState = READ_IDLE;
                end
            endcase
        end
        // writes in the data phase are ignored: the register is read-only
        // a new event wins over the clear of the same bit
        // so an event arriving on the last byte is never lost; the host
        // simply sees it on its next read
        state_nxt.flags = ((state_r.flags & ~clearVec) | setVec) & ~RESERVED_MASK;
        // enabled sources only reach the request line
        // the live sleep bit is a status, not a source, so it never requests
        state_nxt.irq = |(state_nxt.flags & ~LIVE_MASK & interruptEnable);
    end

    // state register; sleep bit reloads from the bus idle level at reset
    // busIdle is only looked at while srst is high; a bus that is idle
    // when the device comes up is treated as already suspended
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_r <= '0;
            state_r.flags <= FLAGS_RESET;
            state_r.rdState <= READ_IDLE;
            state_r.sleep <= busIdle;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // all outputs straight from flops: no glitches on the host side
    assign readData = state_r.dataOut;
    assign interruptRequest = state_r.irq;
    assign busSleepState = state_r.sleep;
endmodule : udis_sources

// ===== hdl/udis_pkg.sv
// constants and types shared by the interrupt source block
package udis_pkg;
    // clock and pseudo frame timing
    localparam int CLOCK_MHZ = 100;
    localparam int PSEUDO_FRAME_US = 1000;
    localparam int PSEUDO_FRAME_CYCLES = PSEUDO_FRAME_US * CLOCK_MHZ;
    localparam int FRAME_CNT_W = 20;
    localparam logic [1:0] MISSED_LIMIT = 2'h3;
    // command codes and read length
    localparam logic [7:0] CMD_READ_SOURCES = 8'hC0;
    localparam logic [1:0] LAST_BYTE = 2'h3;
    // field positions of the source register
    localparam int BIT_BUS_RESET = 0;
    localparam int BIT_RESUME = 1;
    localparam int BIT_SUSPEND_CHANGE = 2;
    localparam int BIT_DMA_DONE = 3;
    localparam int BIT_FRAME_START = 4;
    localparam int BIT_PSEUDO_FRAME = 5;
    localparam int BIT_SHORT_PACKET = 6;
    localparam int BIT_BUS_SLEEP = 7;
    localparam int BIT_CTRL_OUT = 8;
    localparam int BIT_CTRL_IN = 9;
    localparam int BIT_ENDPOINT_BASE = 10;
    localparam int ENDPOINT_COUNT = 14;
    localparam int SOURCE_W = 32;
    localparam logic [SOURCE_W-1:0] FLAGS_RESET = 32'h0000_0000;
    localparam logic [SOURCE_W-1:0] LIVE_MASK = 32'h0000_0080;
    localparam logic [SOURCE_W-1:0] RESERVED_MASK = 32'hFF00_0000;
    // read sequence states
    typedef enum logic [0:0] {READ_IDLE, READ_ACTIVE} udis_read_state_t;
endpackage : udis_pkg

// ===== hdl/udis_frame_if.sv
// signals between the source register and the pseudo frame timer
interface udis_frame_if;
    logic frameStart; // a real frame start was seen on the bus
    logic wakeEvent; // resume or bus reset ends a timer suspend
    logic pseudoTick; // one-cycle pulse each pseudo frame
    logic missedSuspend; // pulse when the missed limit is reached
    modport timer (input frameStart, input wakeEvent, output pseudoTick, output missedSuspend);
    modport owner (output frameStart, output wakeEvent, input pseudoTick, input missedSuspend);
endinterface : udis_frame_if

// ===== hdl/udis_frame_timer.sv
// pseudo frame timer: 1 ms ticks and missed frame counting
module udis_frame_timer
    import udis_pkg::*;
#(
    parameter int FRAME_CYCLES = udis_pkg::PSEUDO_FRAME_CYCLES
)
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // link to the source register
    udis_frame_if.timer frm
);
    import udis_pkg::*;

    localparam logic [FRAME_CNT_W-1:0] FRAME_LAST = FRAME_CNT_W'(FRAME_CYCLES - 1);

    typedef struct packed {
        logic [FRAME_CNT_W-1:0] count; // cycles into the current frame
        logic [1:0] missed; // consecutive frames with no frame start
        logic tick; // pseudo frame pulse
        logic suspendHit; // missed limit pulse
    } udis_timer_state_t;

    udis_timer_state_t state_r;
    udis_timer_state_t state_nxt;

    // a real frame start restarts the frame so ticks stay aligned to the host
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.tick = 1'b0;
        state_nxt.suspendHit = 1'b0;
        if (frm.frameStart || frm.wakeEvent)
        begin
            // traffic seen: the missed run is broken
            state_nxt.count = '0;
            state_nxt.missed = '0;
        end
        else if (state_r.count == FRAME_LAST)
        begin
            // frame elapsed with no frame start
            state_nxt.count = '0;
            state_nxt.tick = 1'b1;
            if (state_r.missed != MISSED_LIMIT)
            begin
                state_nxt.missed = state_r.missed + 2'h1;
                // third miss in a row: report once, then hold
                state_nxt.suspendHit = (state_r.missed == MISSED_LIMIT - 2'h1);
            end
        end
        else
        begin
            state_nxt.count = state_r.count + FRAME_CNT_W'(1);
        end
    end

    // state register
    always_ff @(posedge clock)
    begin
        if (srst)
            state_r <= '0;
        else
            state_r <= state_nxt;
    end

    assign frm.pseudoTick = state_r.tick;
    assign frm.missedSuspend = state_r.suspendHit;
endmodule : udis_frame_timer

// ===== testbench/udis_sources_assertions.sv
// port-level checker for the interrupt source register
module udis_sources_assertions
    import udis_pkg::*;
#(
    parameter int FRAME_CYCLES = 20
)
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // host command port
    input wire logic writeStrobe,
    input wire logic commandPhase,
    input wire logic [7:0] writeData,
    input wire logic readStrobe,
    input wire logic [7:0] readData,
    // event inputs
    input wire logic [ENDPOINT_COUNT-1:0] endpointEvent,
    input wire logic controlInEvent,
    input wire logic controlOutEvent,
    input wire logic shortPacketDone,
    input wire logic dmaCountDone,
    input wire logic frameStartSeen,
    input wire logic resumeSeen,
    input wire logic busResetSeen,
    // mask, request and sleep
    input wire logic busIdle,
    input wire logic [SOURCE_W-1:0] interruptEnable,
    input wire logic interruptRequest,
    input wire logic busSleepState
);
    logic cmdRead; // a read of the source word is taken
    logic busy; // bus activity restarts the frame timer
    logic [31:0] evtVec; // events placed at their flag positions
    int quietCnt_r; // cycles since the last bus activity
    assign cmdRead = writeStrobe && commandPhase && writeData == CMD_READ_SOURCES;
    assign busy = frameStartSeen | resumeSeen | busResetSeen;
    assign evtVec = {8'h00, endpointEvent, controlInEvent, controlOutEvent, 1'b0,
        shortPacketDone, 1'b0, frameStartSeen, dmaCountDone, 1'b0, resumeSeen, busResetSeen};
    // quiet time is what makes sleep legal, so count it here
    always_ff @(posedge clock)
    begin
        quietCnt_r <= (srst || busy) ? 0 : quietCnt_r + 1;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    a_sleep_reset_value: assert property ($fell(srst) |-> busSleepState == $past(busIdle))
        else $error("sleep bit does not follow idle level at reset");
    a_event_sets_request: assert property (|(evtVec & interruptEnable) |=> interruptRequest)
        else $error("enabled event raised no request");
    a_mask_blocks_request: assert property
        ($past(interruptEnable) == 32'h0 && interruptEnable == 32'h0 |-> !interruptRequest)
        else $error("request raised while all sources masked");
    a_read_first_byte: assert property (cmdRead |=> readData[7] == $past(busSleepState))
        else $error("first byte lacks live sleep bit");
    a_top_byte_zero: assert property
        (cmdRead ##1 (readStrobe && !writeStrobe) [*3] |=> readData == 8'h00)
        else $error("reserved byte not zero");
    a_other_cmd_zero: assert property
        (writeStrobe && commandPhase && writeData != CMD_READ_SOURCES |=> readData == 8'h00)
        else $error("unknown command returned data");
    a_activity_wakes: assert property (busy |=> !busSleepState)
        else $error("bus activity did not clear sleep");
    a_sleep_after_misses: assert property
        ($rose(busSleepState) |-> quietCnt_r >= 3 * FRAME_CYCLES)
        else $error("sleep entered too early");
endmodule : udis_sources_assertions

bind udis_sources udis_sources_assertions #(.FRAME_CYCLES(FRAME_CYCLES)) u_udis_sources_assertions
    (.clock, .srst, .writeStrobe, .commandPhase, .writeData, .readStrobe, .readData,
    .endpointEvent, .controlInEvent, .controlOutEvent, .shortPacketDone, .dmaCountDone,
    .frameStartSeen, .resumeSeen, .busResetSeen, .busIdle, .interruptEnable,
    .interruptRequest, .busSleepState);

// ===== testbench/udis_host_model.sv
// host firmware model issuing commands and byte reads
module udis_host_model
(
    // clock
    input wire logic clock,
    // command port
    output logic writeStrobe,
    output logic commandPhase,
    output logic [7:0] writeData,
    output logic readStrobe,
    input wire logic [7:0] readData
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        writeStrobe = 1'b0;
        commandPhase = 1'b0;
        writeData = 8'h00;
        readStrobe = 1'b0;
    end
    // command then nb byte reads, gap idle cycles between them; nb below 4 breaks the rule
    task automatic read_word(input logic [7:0] code, input int nb, input int gap,
        output logic [31:0] w);
        w = 32'h0;
        @(posedge clock);
        #1 writeStrobe = 1'b1;
        commandPhase = 1'b1;
        writeData = code;
        @(posedge clock);
        #1 writeStrobe = 1'b0;
        commandPhase = 1'b0;
        writeData = ~code; // data lines no longer hold the code
        for (int i = 0; i < nb; i++)
        begin
            w[8*i+:8] = readData;
            readStrobe = 1'b1;
            @(posedge clock);
            #1 if (gap > 0 || i == nb - 1) readStrobe = 1'b0;
            // idle cycles end off the edge so the next strobe is not raced
            repeat (gap)
            begin
                @(posedge clock);
                #1;
            end
        end
    endtask : read_word
endmodule : udis_host_model

// ===== testbench/testbench.sv
// self-checking bench for the interrupt source register
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import udis_pkg::*;
    localparam int FRAME = 500; // short pseudo frame keeps the run brief
    logic clock, srst, busIdle, interruptRequest, busSleepState;
    logic writeStrobe, commandPhase, readStrobe;
    logic [7:0] writeData, readData;
    logic [31:0] srcPulse, interruptEnable, w; // events by flag position, mask, read word
    int error_cnt = 0, num_checks = 0, cycles = 0;
    udis_sources #(.FRAME_CYCLES(FRAME)) u_udis_sources (.clock, .srst, .writeStrobe,
        .commandPhase, .writeData, .readStrobe, .readData, .endpointEvent(srcPulse[23:10]),
        .controlInEvent(srcPulse[9]), .controlOutEvent(srcPulse[8]),
        .shortPacketDone(srcPulse[6]), .dmaCountDone(srcPulse[3]), .frameStartSeen(srcPulse[4]),
        .resumeSeen(srcPulse[1]), .busResetSeen(srcPulse[0]), .busIdle, .interruptEnable,
        .interruptRequest, .busSleepState);
    udis_host_model u_udis_host_model (.clock, .writeStrobe, .commandPhase, .writeData,
        .readStrobe, .readData);
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            conclude();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude
    task automatic do_reset(input logic idle);
        @(posedge clock);
        #1 srst = 1'b1;
        busIdle = idle;
        repeat (16) @(posedge clock);
        #1 srst = 1'b0;
    endtask : do_reset
    task automatic pulse(input int k);
        @(posedge clock);
        #1 srcPulse = 32'h1 << k;
        @(posedge clock);
        #1 srcPulse = 32'h0;
    endtask : pulse
    task automatic rd(input logic [7:0] code, input int nb, input int gap);
        u_udis_host_model.read_word(code, nb, gap, w);
    endtask : rd
    initial
    begin
        srcPulse = 32'h0;
        interruptEnable = 32'hFFFF_FFFF;
        srst = 1'b1;
        busIdle = 1'b1;
        do_reset(1'b1);
        check({31'h0, busSleepState}, 32'h1, "sleep after idle reset");
        rd(CMD_READ_SOURCES, 4, 0);
        check(w, 32'h0000_0080, "word after reset");
        // each pulsed source alone, flags 2, 5 and 7 skipped; odd ones enabled, even ones fully masked
        for (int k = 0; k < 24; k++)
        begin
            if (k == 2 || k == 5 || k == 7) continue;
            interruptEnable = {32{k[0]}};
            pulse(k);
            @(posedge clock);
            #1 check({31'h0, interruptRequest}, {31'h0, k[0]}, "request level");
            rd(CMD_READ_SOURCES, 4, k % 3);
            check(w, 32'h1 << k, "source flag");
            @(posedge clock);
            #1 check({31'h0, interruptRequest}, 32'h0, "request after read");
        end
        pulse(23);
        rd(8'hB4, 4, 0);
        check(w, 32'h0, "unknown command");
        rd(CMD_READ_SOURCES, 2, 1);
        check(w, 32'h0, "partial read");
        rd(CMD_READ_SOURCES, 4, 0);
        check(w, 32'h0080_0000, "flag kept by partial read");
        pulse(4);
        rd(CMD_READ_SOURCES, 4, 0);
        check(w, 32'h0000_0010, "frame start");
        repeat (FRAME) @(posedge clock);
        rd(CMD_READ_SOURCES, 4, 0);
        check(w, 32'h0000_0020, "one pseudo frame");
        repeat (2 * FRAME) @(posedge clock);
        #1 check({31'h0, busSleepState}, 32'h1, "sleep after misses");
        rd(CMD_READ_SOURCES, 4, 0);
        check(w, 32'h0000_00A4, "suspend change");
        pulse(1);
        @(posedge clock);
        #1 check({31'h0, busSleepState}, 32'h0, "resume wakes");
        do_reset(1'b0);
        check({31'h0, busSleepState}, 32'h0, "sleep after busy reset");
        conclude();
    end
endmodule : testbench
